// ---- src/asf_conv_fifo_level.sv ----
// conversion fifo occupancy counter with full and empty flags
`timescale 1ns/1ns
module asf_conv_fifo_level #(
  parameter int DEPTH = 512
) (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   sys_rst,
  // events
  input  wire logic                   push,
  input  wire logic                   pop,
  // level
  output logic [$clog2(DEPTH+1)-1:0]  level,
  output logic                        full,
  output logic                        empty
);
  import asf_pkg::*;
  localparam int LW = $clog2(DEPTH+1);
  typedef struct packed {logic [LW-1:0] cnt;} asf_lv_type;
  asf_lv_type state_reg;
  asf_lv_type state_next;
  logic doPush;
  logic doPop;
  always_comb begin
    state_next = state_reg;
    // a pop in the same cycle makes room for the push
    doPush = push && ((state_reg.cnt != LW'(DEPTH)) || pop);
    doPop  = pop && (state_reg.cnt != '0);
    if (doPush && !doPop) begin
      state_next.cnt = state_reg.cnt + 1'b1;
    end else if (doPop && !doPush) begin
      state_next.cnt = state_reg.cnt - 1'b1;
    end
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
  assign level = state_reg.cnt;
  assign full  = (state_reg.cnt == LW'(DEPTH));
  assign empty = (state_reg.cnt == '0);
  a_level_bound: assert property (@(posedge clock) disable iff (sys_rst)
    state_reg.cnt <= LW'(DEPTH)) else $error("fifo level beyond depth");
endmodule : asf_conv_fifo_level

// ---- src/asf_pkg.sv ----
// package: offsets, bit positions, reset values and carrier types
package asf_pkg;
  localparam logic [7:0]  ASF_STATUS_OFS  = 8'h18;
  localparam logic [7:0]  ASF_CTRL_OFS    = 8'h1c;
  localparam logic [7:0]  ASF_CLRACQ_OFS  = 8'h20;
  localparam logic [7:0]  ASF_CLRTCA_OFS  = 8'h22;
  localparam logic [7:0]  ASF_CLRTCB_OFS  = 8'h24;
  localparam logic [7:0]  ASF_CLRTMR_OFS  = 8'h26;
  localparam logic [7:0]  ASF_START_OFS   = 8'h28;
  localparam int          ASF_BIT_DONE    = 15;
  localparam int          ASF_BIT_ACTIVE  = 14;
  localparam int          ASF_BIT_HALF_N  = 13;
  localparam int          ASF_BIT_NONEMPTY = 12;
  localparam int          ASF_BIT_TCA     = 11;
  localparam int          ASF_BIT_TCB     = 10;
  localparam int          ASF_BIT_OVFL    = 9;
  localparam int          ASF_BIT_OVRN    = 8;
  localparam int          ASF_BIT_TMR     = 7;
  localparam int          ASF_BIT_OSEQ    = 6;
  localparam int          ASF_BIT_ONF     = 5;
  localparam int          ASF_FIFO_DEPTH  = 512;
  localparam int          ASF_HALF_LEVEL  = 256;
  localparam logic [15:0] ASF_DATA_RESET  = 16'h0000;
  // control register fields
  localparam int          ASF_CTL_REQEN   = 0;
  localparam int          ASF_CTL_HALFREQ = 1;
  localparam int          ASF_CTL_TMRINT  = 2;
  localparam int          ASF_CTL_TMRDMA  = 3;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [15:0] wdata;
  } asf_bus_type;

  typedef struct packed {
    logic convDone;
    logic convStart;
    logic convBusy;
    logic tcA;
    logic tcB;
    logic outFifoNotFull;
    logic timerPulse_n;
    logic outConvWrite;
    logic outSeqDone;
  } asf_event_type;
endpackage : asf_pkg

// ---- src/asf_status.sv ----
// acquisition status word with sticky flags and clear strobes
//
// Overview of operation
// R1 - status word read-only at offset 0x18
// R2 - bit 15 follows acquisition termination
// R3 - done plus enable keeps requests until empty
// R4 - done clears only by acquisition clear strobe
// R5 - bit 14 high while acquisition runs
// R6 - bit 13 low when 256 or more held
// R7 - software drains fifo to clear half-full
// R8 - bit 12 high when data held, no request empty
// R9 - bit 11 sticky on channel A terminal count
// R10 - bit 10 sticky on channel B terminal count
// R11 - bit 9 set when full fifo loses data
// R12 - overflow stops acquisition, cleared by strobe
// R13 - bit 8 set on conversion start while busy
// R14 - overrun stops acquisition, cleared by strobe
// R15 - bit 7 on output room or timer pulse; the code counts the timer pulse only with ASF_CTL_TMRINT set
// R16 - timer request raised only in selected mode
// R17 - dma mode: output write clears timer request
// R18 - software clears timer request by strobe
// R19 - bit 6 output sequence done, clear while running
// R20 - bit 5 high when output fifo not full
// R21 - reads have no side effects, coherent snapshot
`timescale 1ns/1ns
module asf_status #(
  parameter int DEPTH = 512
) (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  sys_rst,
  // register port
  input  wire asf_pkg::asf_bus_type  bus,
  output logic [15:0]                rdData,
  // board events
  input  wire asf_pkg::asf_event_type ev,
  input  wire logic                  fifoRead,
  // requests and running state
  output logic                       convRequest,
  output logic                       timerRequest,
  output logic                       acqRunning
);
  import asf_pkg::*;
  localparam int LW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [15:0] rd;
    logic [3:0]  ctrl;
    logic        active;
    logic        seqRun;
    logic        convReq;
    logic        update_timer_request;
    logic        running;
  } asf_state_type;

  asf_state_type state_reg;
  asf_state_type state_next;
  logic [LW-1:0] level;
  logic          full;
  logic          empty;
  logic          done, tca, tcb, ovfl, ovrn, tmr, oseq;
  logic          wrHit;
  logic          clrAcq, clrTca, clrTcb, clrTmr, startAcq;
  logic          ovflEv, ovrnEv, tmrSet, tmrClr, stopEv;
  logic [15:0]   word;

  assign wrHit    = bus.wr;
  assign clrAcq   = wrHit && bus.addr == ASF_CLRACQ_OFS;
  assign clrTca   = wrHit && bus.addr == ASF_CLRTCA_OFS;
  assign clrTcb   = wrHit && bus.addr == ASF_CLRTCB_OFS;
  assign clrTmr   = wrHit && bus.addr == ASF_CLRTMR_OFS;
  assign startAcq = wrHit && bus.addr == ASF_START_OFS;

  asf_conv_fifo_level #(.DEPTH(DEPTH)) uLevel (
    .clock   (clock),
    .sys_rst (sys_rst),
    .push    (ev.convDone),
    .pop     (fifoRead),
    .level   (level),
    .full    (full),
    .empty   (empty)
  );

  assign ovflEv = ev.convDone && full && !fifoRead; // R11
  assign ovrnEv = ev.convStart && ev.convBusy; // R13
  assign stopEv = state_reg.active && (ovflEv || ovrnEv); // R12 R14
  // R15 R16
  assign tmrSet = ev.outFifoNotFull ||
                  (state_reg.ctrl[ASF_CTL_TMRINT] && !ev.timerPulse_n);
  assign tmrClr = clrTmr ||
                  (state_reg.ctrl[ASF_CTL_TMRDMA] && ev.outConvWrite); // R17

  asf_sticky_bit uDone (.clock(clock), .sys_rst(sys_rst),
    .setIn(stopEv), .clrIn(clrAcq), .flag(done)); // R2 R4
  asf_sticky_bit uOvfl (.clock(clock), .sys_rst(sys_rst),
    .setIn(ovflEv), .clrIn(clrAcq), .flag(ovfl)); // R11 R12
  asf_sticky_bit uOvrn (.clock(clock), .sys_rst(sys_rst),
    .setIn(ovrnEv), .clrIn(clrAcq), .flag(ovrn)); // R13 R14
  asf_sticky_bit uTca (.clock(clock), .sys_rst(sys_rst),
    .setIn(ev.tcA), .clrIn(clrTca), .flag(tca)); // R9
  asf_sticky_bit uTcb (.clock(clock), .sys_rst(sys_rst),
    .setIn(ev.tcB), .clrIn(clrTcb), .flag(tcb)); // R10
  asf_sticky_bit uTmr (.clock(clock), .sys_rst(sys_rst),
    .setIn(tmrSet), .clrIn(tmrClr), .flag(tmr)); // R15 R17 R18
  asf_sticky_bit uOseq (.clock(clock), .sys_rst(sys_rst),
    .setIn(ev.outSeqDone), .clrIn(ev.outConvWrite),
    .flag(oseq)); // R19

  always_comb begin
    word = ASF_DATA_RESET;
    word[ASF_BIT_DONE]     = done; // R2
    word[ASF_BIT_ACTIVE]   = state_reg.active; // R5
    word[ASF_BIT_HALF_N]   = (level < LW'(ASF_HALF_LEVEL)); // R6
    word[ASF_BIT_NONEMPTY] = !empty; // R8
    word[ASF_BIT_TCA]      = tca; // R9
    word[ASF_BIT_TCB]      = tcb; // R10
    word[ASF_BIT_OVFL]     = ovfl; // R11
    word[ASF_BIT_OVRN]     = ovrn; // R13
    word[ASF_BIT_TMR]      = tmr; // R15
    word[ASF_BIT_OSEQ]     = oseq && !state_reg.seqRun; // R19
    word[ASF_BIT_ONF]      = ev.outFifoNotFull; // R20
  end

  always_comb begin
    state_next = state_reg;
    state_next.rd = 16'h0000;
    if (bus.rd) begin
      unique case (bus.addr)
        ASF_STATUS_OFS: state_next.rd = word; // R1 R21
        ASF_CTRL_OFS:   state_next.rd = {12'h000, state_reg.ctrl};
        default:        state_next.rd = 16'h0000;
      endcase
    end
    if (wrHit && bus.addr == ASF_CTRL_OFS) begin
      state_next.ctrl = bus.wdata[3:0];
    end
    if (startAcq) begin
      state_next.active = 1'b1;
    end else if (stopEv) begin
      state_next.active = 1'b0; // R5 R12 R14
    end
    if (ev.outSeqDone) begin
      state_next.seqRun = 1'b0;
    end else if (ev.outConvWrite) begin
      state_next.seqRun = 1'b1;
    end
    // R3 R8
    if (empty || !state_reg.ctrl[ASF_CTL_REQEN]) begin
      state_next.convReq = 1'b0;
    end else if (done) begin
      state_next.convReq = 1'b1; // R3
    end else if (state_reg.ctrl[ASF_CTL_HALFREQ]) begin
      state_next.convReq = state_reg.convReq ||
                           level >= LW'(ASF_HALF_LEVEL);
    end else begin
      state_next.convReq = 1'b1;
    end
    // R16
    state_next.update_timer_request = tmr && (state_reg.ctrl[ASF_CTL_TMRINT] ||
                                state_reg.ctrl[ASF_CTL_TMRDMA]);
    state_next.running = state_next.active;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdData       = state_reg.rd;
  assign convRequest  = state_reg.convReq;
  assign timerRequest = state_reg.update_timer_request;
  assign acqRunning   = state_reg.running;

  a_read_status: assert property (@(posedge clock) disable iff (sys_rst)
    bus.rd && bus.addr == ASF_STATUS_OFS |=> rdData == $past(word)) // R1
    else $error("status read mismatch");
  a_done_hold: assert property (@(posedge clock) disable iff (sys_rst)
    done && !clrAcq |=> done) else $error("done dropped"); // R4
  a_empty_noreq: assert property (@(posedge clock) disable iff (sys_rst)
    empty |=> !convRequest) else $error("request while empty"); // R8
  a_stop_on_err: assert property (@(posedge clock) disable iff (sys_rst)
    stopEv && !startAcq |=> !state_reg.active ##0 done) // R12
    else $error("error did not stop acquisition");
  a_tca_sticky: assert property (@(posedge clock) disable iff (sys_rst)
    ev.tcA |=> tca ##1 (tca || $past(clrTca))) // R9
    else $error("channel A flag lost");
  a_tcb_sticky: assert property (@(posedge clock) disable iff (sys_rst)
    tcb && !clrTcb |=> tcb) else $error("channel B flag lost"); // R10
  a_tmr_mode: assert property (@(posedge clock) disable iff (sys_rst)
    timerRequest |-> $past(state_reg.ctrl[ASF_CTL_TMRINT] ||
                           state_reg.ctrl[ASF_CTL_TMRDMA])) // R16
    else $error("timer request outside mode");
  a_ovrn_set: assert property (@(posedge clock) disable iff (sys_rst)
    ovrnEv |=> ovrn) else $error("overrun missed"); // R13
  a_half_flag: assert property (@(posedge clock) disable iff (sys_rst) // R6
    bus.rd && bus.addr == ASF_STATUS_OFS && level >= LW'(ASF_HALF_LEVEL)
    |=> !rdData[ASF_BIT_HALF_N])
    else $error("half flag wrong");
  c_clean_done: cover property (@(posedge clock) done && !ovfl && !ovrn);
  c_overflow: cover property (@(posedge clock) ovflEv);
  c_timer: cover property (@(posedge clock) timerRequest);
  c_drain: cover property (@(posedge clock) convRequest ##1 !convRequest);
endmodule : asf_status

// ---- src/asf_sticky_bit.sv ----
// sticky flag: set wins over clear
`timescale 1ns/1ns
module asf_sticky_bit (
  // clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  // control
  input  wire logic setIn,
  input  wire logic clrIn,
  // flag
  output logic      flag
);
  import asf_pkg::*;
  typedef struct packed {logic f;} asf_sb_type;
  asf_sb_type state_reg;
  asf_sb_type state_next;
  always_comb begin
    state_next = state_reg;
    if (clrIn) begin
      state_next.f = 1'b0;
    end
    if (setIn) begin
      state_next.f = 1'b1;
    end
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
  assign flag = state_reg.f;
  a_sticky_set_wins: assert property (@(posedge clock) disable iff (sys_rst)
    setIn |=> flag) else $error("sticky flag missed a set");
endmodule : asf_sticky_bit

// ---- testbench/asf_status_test.sv ----
// self-checking bench for the acquisition status word
`timescale 1ns/1ns
module asf_status_test;
  import asf_pkg::*;
  localparam int EV_DONE = 8;
  localparam int EV_START = 7;
  localparam int EV_TCA = 5;
  localparam int EV_TCB = 4;
  localparam int EV_ONF = 3;
  localparam int EV_TMRN = 2;
  localparam int EV_OWR = 1;
  localparam int EV_OSEQ = 0;
  logic          clock;
  logic          sys_rst;
  asf_bus_type   bus;
  asf_event_type ev;
  logic          fifoRead;
  logic [15:0]   rdData;
  logic          convRequest;
  logic          timerRequest;
  logic          acqRunning;
  int            bad_count;
  int            total_checks;
  int            cycles = 0;
  int            level;
  int            n;
  logic [15:0]   flags;
  logic [15:0]   got;

  asf_status #(.DEPTH(ASF_FIFO_DEPTH)) u_asf_status (
    .clock(clock), .sys_rst(sys_rst), .bus(bus), .rdData(rdData),
    .ev(ev), .fifoRead(fifoRead), .convRequest(convRequest),
    .timerRequest(timerRequest), .acqRunning(acqRunning));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // expected status word from the model
  function automatic logic [15:0] want();
    logic [15:0] w;
    w = flags;
    w[ASF_BIT_HALF_N] = (level < ASF_HALF_LEVEL);
    w[ASF_BIT_NONEMPTY] = (level > 0);
    w[ASF_BIT_ONF] = ev.outFifoNotFull;
    return w;
  endfunction : want

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge clock);
    bus.wr <= 1'b0;
    repeat (2) @(posedge clock);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge clock);
    bus.rd <= 1'b0;
    #1 d = rdData;
    @(posedge clock);
  endtask : rd

  task automatic stat();
    rd(ASF_STATUS_OFS, got);
    check(got, want());
    check({15'h0000, acqRunning}, {15'h0000, flags[ASF_BIT_ACTIVE]});
  endtask : stat

  // one-cycle toggle of an event bit
  task automatic pulse(input int b);
    ev[b] <= ~ev[b];
    @(posedge clock);
    ev[b] <= ~ev[b];
    @(posedge clock);
  endtask : pulse

  task automatic halt();
    if (flags[ASF_BIT_ACTIVE]) begin
      flags[ASF_BIT_ACTIVE] = 1'b0;
      flags[ASF_BIT_DONE] = 1'b1;
    end
  endtask : halt

  task automatic push(input int k);
    repeat (k) begin
      pulse(EV_DONE);
      if (level < ASF_FIFO_DEPTH) begin
        level++;
      end else begin
        flags[ASF_BIT_OVFL] = 1'b1;
        halt();
      end
    end
  endtask : push

  task automatic pop(input int k);
    repeat (k) begin
      fifoRead <= 1'b1;
      @(posedge clock);
      fifoRead <= 1'b0;
      @(posedge clock);
      level--;
    end
  endtask : pop

  initial begin
    bus = '0;
    ev = '0;
    ev.timerPulse_n = 1'b1;
    fifoRead = 1'b0;
    sys_rst = 1'b1;
    {bad_count, total_checks, level} = '0;
    flags = 16'h0000;
    void'($urandom(49));
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    stat();
    rd(8'h30, got);
    check(got, 16'h0000);
    wr(ASF_STATUS_OFS, 16'hffff);
    stat();
    wr(ASF_CTRL_OFS, 16'h0001);
    n = $urandom_range(255, 1);
    push(n);
    stat();
    check({15'h0000, convRequest}, 16'h0001);
    push(ASF_HALF_LEVEL - n);
    stat();
    pop(ASF_HALF_LEVEL);
    stat();
    check({15'h0000, convRequest}, 16'h0000);
    wr(ASF_CTRL_OFS, 16'h0003);
    push(n);
    stat();
    check({15'h0000, convRequest}, 16'h0000);
    push(ASF_HALF_LEVEL - n);
    pop(1);
    stat();
    check({15'h0000, convRequest}, 16'h0001);
    pop(ASF_HALF_LEVEL - 1);
    stat();
    check({15'h0000, convRequest}, 16'h0000);
    pulse(EV_TCA);
    pulse(EV_TCB);
    flags[ASF_BIT_TCA] = 1'b1;
    flags[ASF_BIT_TCB] = 1'b1;
    stat();
    stat();
    wr(ASF_CLRTCA_OFS, 16'h0000);
    flags[ASF_BIT_TCA] = 1'b0;
    stat();
    wr(ASF_CLRTCB_OFS, 16'h0000);
    flags[ASF_BIT_TCB] = 1'b0;
    stat();
    wr(ASF_START_OFS, 16'h0000);
    flags[ASF_BIT_ACTIVE] = 1'b1;
    stat();
    ev.convBusy <= 1'b1;
    @(posedge clock);
    pulse(EV_START);
    ev.convBusy <= 1'b0;
    flags[ASF_BIT_OVRN] = 1'b1;
    halt();
    stat();
    stat();
    push(1);
    stat();
    check({15'h0000, convRequest}, 16'h0001);
    pop(1);
    stat();
    check({15'h0000, convRequest}, 16'h0000);
    wr(ASF_CLRACQ_OFS, 16'h0000);
    flags[ASF_BIT_DONE] = 1'b0;
    flags[ASF_BIT_OVRN] = 1'b0;
    stat();
    wr(ASF_START_OFS, 16'h0000);
    flags[ASF_BIT_ACTIVE] = 1'b1;
    push(ASF_FIFO_DEPTH + 1);
    stat();
    wr(ASF_CLRACQ_OFS, 16'h0000);
    flags[ASF_BIT_DONE] = 1'b0;
    flags[ASF_BIT_OVFL] = 1'b0;
    stat();
    pop(ASF_FIFO_DEPTH);
    ev.outFifoNotFull <= 1'b1;
    repeat (2) @(posedge clock);
    flags[ASF_BIT_TMR] = 1'b1;
    stat();
    check({15'h0000, timerRequest}, 16'h0000);
    ev.outFifoNotFull <= 1'b0;
    wr(ASF_CLRTMR_OFS, 16'h0000);
    flags[ASF_BIT_TMR] = 1'b0;
    stat();
    wr(ASF_CTRL_OFS, 16'h0004);
    pulse(EV_TMRN);
    flags[ASF_BIT_TMR] = 1'b1;
    stat();
    check({15'h0000, timerRequest}, 16'h0001);
    wr(ASF_CLRTMR_OFS, 16'h0000);
    flags[ASF_BIT_TMR] = 1'b0;
    stat();
    wr(ASF_CTRL_OFS, 16'h0008);
    pulse(EV_ONF);
    flags[ASF_BIT_TMR] = 1'b1;
    stat();
    pulse(EV_OWR);
    flags[ASF_BIT_TMR] = 1'b0;
    stat();
    pulse(EV_OSEQ);
    flags[ASF_BIT_OSEQ] = 1'b1;
    stat();
    finish_test();
  end
endmodule : asf_status_test
